// ---- logic_output_pkg.sv ----
// Holds the shared constants, function codes and carrier types of the output selector.
// Assumes a single control clock at 250 MHz and a plain register port with 16-bit data.
package logic_output_pkg;

  // Sizes
  localparam int N_OUT  = 7;
  localparam int SEL_W  = 5;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;

  // Output function codes
  typedef enum logic [SEL_W-1:0] {
    FN_NONE, FN_NOT_ALARM, FN_GROUND_FLT, FN_OVERCURR_FLT, FN_OVERTEMP_FLT, FN_OVERVOLT_FLT,
    FN_OVERTEMP_ALARM, FN_MOTOR_TRQ_LIM, FN_REGEN_TRQ_LIM, FN_RAMP_DOWN, FN_DRIVE_PREPARED,
    FN_RUN_COMMANDED, FN_RUN_CONFIRM, FN_SPEED_DEV, FN_SPEED_DEV_LOW, FN_REF_RELEASE,
    FN_REFERENCE_UNLOCK_MULTISTEP, FN_LOW_GAIN, FN_FUSE_FLT, FN_PHASE_LOSS, FN_MOTOR_OVERLOAD,
    FN_OVERSPEED_FLT, FN_COUNT
  } out_fn_t;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] ADDR_SEL_BASE   = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STEP       = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_RATED      = 8'h1C;
  localparam logic [ADDR_W-1:0] ADDR_DEV_LEVEL  = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_DEV_BAND   = 8'h24;
  localparam logic [ADDR_W-1:0] ADDR_DEV_TIME   = 8'h28;
  localparam logic [ADDR_W-1:0] ADDR_OVS_PCT    = 8'h2C;
  localparam logic [ADDR_W-1:0] ADDR_CONTRACT   = 8'h30;
  localparam logic [ADDR_W-1:0] ADDR_OVS_TIME   = 8'h34;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG     = 8'h38;
  localparam logic [ADDR_W-1:0] ADDR_STATUS     = 8'h3C;

  // Config register fields
  localparam int CFG_CLASS_BIT = 0;
  localparam int CFG_SRC_LSB   = 1;
  localparam logic [1:0] VEL_SRC_MULTISTEP = 2'h1;

  // Reset selections
  localparam logic [SEL_W-1:0] SEL_RST_0 = FN_DRIVE_PREPARED;
  localparam logic [SEL_W-1:0] SEL_RST_1 = FN_RUN_COMMANDED;
  localparam logic [SEL_W-1:0] SEL_RST_2 = FN_MOTOR_OVERLOAD;
  localparam logic [SEL_W-1:0] SEL_RST_N = FN_NONE;

  // Trip thresholds
  localparam logic [16:0] PCT_FULL   = 17'h00064;
  localparam logic [16:0] GF_PCT     = 17'h00032;
  localparam logic [16:0] OC_PCT     = 17'h0012C;
  localparam logic [7:0]  OT_FLT_C   = 8'h5A;
  localparam logic [7:0]  OT_ALM_C   = 8'h50;
  localparam logic [15:0] OV_460_V   = 16'h0352;
  localparam logic [15:0] OV_230_V   = 16'h01A9;

  // Timing: millisecond tick for the user timers
  localparam int CLK_NS  = 4;
  localparam int TICK_NS = 1000000;

  // Drive status flags, from logic on the control clock
  typedef struct packed {
    logic       init_done;
    logic [7:0] alarm_src;
    logic [7:0] fault_src;
    logic       run_cmd;
    logic       contactor_closed;
    logic       contact_confirm_used;
    logic       gates_firing;
    logic       torque_limit;
    logic       motoring;
    logic       ramp_req_input;
    logic       ramp_req_serial;
    logic       ramp_req_internal;
    logic       flux_confirmed;
    logic       dc_injection;
    logic       low_gain;
    logic       fuse_blown;
    logic       phase_open;
    logic       motor_overload;
  } status_t;

  // Measurements, same units as the matching settings
  typedef struct packed {
    logic [15:0]        isum;
    logic [15:0]        iphase;
    logic [7:0]         temp_c;
    logic [15:0]        vbus;
    logic signed [15:0] spd_ref;
    logic signed [15:0] spd_fbk;
  } meas_t;

  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } bus_req_t;

endpackage

// ---- logic_output_select.sv ----
// Holds the function selector for the drive's logic outputs, relays and user LED.
// Assumes status flags and measurements come from logic on mclk_in, and a plain register port.
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module logic_output_select #(
  parameter int TICK_CYCLES = logic_output_pkg::TICK_NS / logic_output_pkg::CLK_NS
) (
  input  wire logic                                    mclk_in,
  input  wire logic                                    nrst_in,
  input  wire logic_output_pkg::status_t               status_in,
  input  wire logic_output_pkg::meas_t                 meas_in,
  input  wire logic_output_pkg::bus_req_t              bus_in,
  output logic      [logic_output_pkg::DATA_W-1:0]     rdata_out,
  output logic      [logic_output_pkg::N_OUT-1:0]      term_out,
  output logic                                         alarm_out,
  output logic                                         fault_out
);
  import logic_output_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [N_OUT-1:0][SEL_W-1:0] sel;
    logic [15:0]                 rated;
    logic [15:0]                 dev_level;
    logic [15:0]                 dev_band;
    logic [15:0]                 dev_time;
    logic [15:0]                 ovs_pct;
    logic [15:0]                 contract;
    logic [15:0]                 ovs_time;
    logic                        class_460;
    logic [1:0]                  vel_src;
    logic                        ramp;
    logic [17:0]                 tick;
    logic [15:0]                 low_cnt;
    logic                        low_ok;
    logic [15:0]                 ovs_cnt;
    logic                        ovs_ok;
    logic [N_OUT-1:0]            term;
    logic                        alarm;
    logic                        fault;
    logic [DATA_W-1:0]           rdata;
  } state_t;

  state_t st_q;
  state_t st_d;

  localparam logic [17:0] TICK_LAST = 18'(TICK_CYCLES - 1);

  //////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [33:0] pct_of(input logic [16:0] v, input logic [16:0] p);
    pct_of = v * p;
  endfunction

  function automatic logic [16:0] mag(input logic signed [16:0] v);
    mag = v[16] ? 17'(-v) : 17'(v);
  endfunction

  function automatic logic [ADDR_W-1:0] sel_addr(input int i);
    sel_addr = ADDR_SEL_BASE + ADDR_W'(i * int'(ADDR_STEP));
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  logic signed [16:0] err;
  logic               tick;
  logic               gf_trip;
  logic               oc_trip;
  logic               ot_trip;
  logic               ov_trip;
  logic               ota_trip;
  logic               in_band;
  logic               over_spd;
  logic               prepared;
  logic               run_ok;
  logic [FN_COUNT-1:0] cond;

  always_comb begin
    st_d     = st_q;
    err      = 17'(meas_in.spd_ref) - 17'(meas_in.spd_fbk);
    tick     = (st_q.tick == TICK_LAST);
    st_d.tick = tick ? '0 : st_q.tick + 18'h00001;

    // Threshold trips
    gf_trip  = pct_of({1'b0, meas_in.isum}, PCT_FULL) > pct_of({1'b0, st_q.rated}, GF_PCT);
    oc_trip  = pct_of({1'b0, meas_in.iphase}, PCT_FULL) > pct_of({1'b0, st_q.rated}, OC_PCT);
    ot_trip  = meas_in.temp_c > OT_FLT_C;
    ota_trip = meas_in.temp_c > OT_ALM_C;
    ov_trip  = meas_in.vbus > (st_q.class_460 ? OV_460_V : OV_230_V);
    in_band  = mag(err) <= {1'b0, st_q.dev_band};
    over_spd = pct_of(mag(17'(meas_in.spd_fbk)), PCT_FULL) >
               pct_of({1'b0, st_q.contract}, {1'b0, st_q.ovs_pct});

    // Alarm and fault indications
    st_d.alarm = (|status_in.alarm_src) | ota_trip;
    st_d.fault = (|status_in.fault_src) | gf_trip | oc_trip | ot_trip | ov_trip |
                 status_in.fuse_blown | status_in.phase_open | status_in.motor_overload |
                 st_q.ovs_ok;
    prepared = status_in.init_done & ~st_d.fault;
    run_ok   = status_in.run_cmd & (~status_in.contact_confirm_used | status_in.contactor_closed);

    // Ramp stop latch: a request wins over the clear by run removal
    if (!status_in.run_cmd) begin
      st_d.ramp = 1'b0;
    end
    if (status_in.ramp_req_input | status_in.ramp_req_serial | status_in.ramp_req_internal) begin
      st_d.ramp = 1'b1;
    end

    // Low deviation qualifier timer
    if (!in_band) begin
      st_d.low_cnt = '0;
      st_d.low_ok  = 1'b0;
    end else if (tick) begin
      if (st_q.low_cnt >= st_q.dev_time) begin
        st_d.low_ok = 1'b1;
      end else begin
        st_d.low_cnt = st_q.low_cnt + 16'h0001;
      end
    end

    // Overspeed qualifier timer
    if (!over_spd) begin
      st_d.ovs_cnt = '0;
      st_d.ovs_ok  = 1'b0;
    end else if (tick) begin
      if (st_q.ovs_cnt >= st_q.ovs_time) begin
        st_d.ovs_ok = 1'b1;
      end else begin
        st_d.ovs_cnt = st_q.ovs_cnt + 16'h0001;
      end
    end

    // Condition per function code
    cond                                = '0;
    cond[FN_NOT_ALARM]                  = ~st_d.alarm;
    cond[FN_GROUND_FLT]                 = gf_trip;
    cond[FN_OVERCURR_FLT]               = oc_trip;
    cond[FN_OVERTEMP_FLT]               = ot_trip;
    cond[FN_OVERVOLT_FLT]               = ov_trip;
    cond[FN_OVERTEMP_ALARM]             = ota_trip;
    cond[FN_MOTOR_TRQ_LIM]              = status_in.torque_limit & status_in.motoring;
    cond[FN_REGEN_TRQ_LIM]              = status_in.torque_limit & ~status_in.motoring;
    cond[FN_RAMP_DOWN]                  = st_q.ramp;
    cond[FN_DRIVE_PREPARED]             = prepared;
    cond[FN_RUN_COMMANDED]              = status_in.run_cmd;
    cond[FN_RUN_CONFIRM]                = prepared & status_in.run_cmd &
                                          status_in.contactor_closed & status_in.gates_firing;
    cond[FN_SPEED_DEV]                  = err > $signed({1'b0, st_q.dev_level});
    cond[FN_SPEED_DEV_LOW]              = st_q.low_ok & in_band;
    cond[FN_REF_RELEASE]                = status_in.flux_confirmed & ~status_in.dc_injection;
    cond[FN_REFERENCE_UNLOCK_MULTISTEP] = prepared & run_ok & ~status_in.dc_injection &
                                          (st_q.vel_src == VEL_SRC_MULTISTEP);
    cond[FN_LOW_GAIN]                   = status_in.low_gain;
    cond[FN_FUSE_FLT]                   = status_in.fuse_blown;
    cond[FN_PHASE_LOSS]                 = status_in.phase_open;
    cond[FN_MOTOR_OVERLOAD]             = status_in.motor_overload;
    cond[FN_OVERSPEED_FLT]              = st_q.ovs_ok;

    // Each output picks its own condition; unknown codes read false
    for (int i = 0; i < N_OUT; i++) begin
      st_d.term[i] = (st_q.sel[i] < SEL_W'(FN_COUNT)) ? cond[st_q.sel[i]] : 1'b0;
    end

    // Register writes
    if (bus_in.wr) begin
      for (int i = 0; i < N_OUT; i++) begin
        if (bus_in.addr == sel_addr(i)) begin
          st_d.sel[i] = bus_in.wdata[SEL_W-1:0];
        end
      end
      if (bus_in.addr == ADDR_RATED) begin
        st_d.rated = bus_in.wdata;
      end else if (bus_in.addr == ADDR_DEV_LEVEL) begin
        st_d.dev_level = bus_in.wdata;
      end else if (bus_in.addr == ADDR_DEV_BAND) begin
        st_d.dev_band = bus_in.wdata;
      end else if (bus_in.addr == ADDR_DEV_TIME) begin
        st_d.dev_time = bus_in.wdata;
      end else if (bus_in.addr == ADDR_OVS_PCT) begin
        st_d.ovs_pct = bus_in.wdata;
      end else if (bus_in.addr == ADDR_CONTRACT) begin
        st_d.contract = bus_in.wdata;
      end else if (bus_in.addr == ADDR_OVS_TIME) begin
        st_d.ovs_time = bus_in.wdata;
      end else if (bus_in.addr == ADDR_CONFIG) begin
        st_d.class_460 = bus_in.wdata[CFG_CLASS_BIT];
        st_d.vel_src   = bus_in.wdata[CFG_SRC_LSB+1:CFG_SRC_LSB];
      end
    end

    // Register reads, data valid only in the cycle after the strobe
    st_d.rdata = '0;
    if (bus_in.rd) begin
      for (int i = 0; i < N_OUT; i++) begin
        if (bus_in.addr == sel_addr(i)) begin
          st_d.rdata = DATA_W'(st_q.sel[i]);
        end
      end
      if (bus_in.addr == ADDR_RATED) begin
        st_d.rdata = st_q.rated;
      end else if (bus_in.addr == ADDR_DEV_LEVEL) begin
        st_d.rdata = st_q.dev_level;
      end else if (bus_in.addr == ADDR_DEV_BAND) begin
        st_d.rdata = st_q.dev_band;
      end else if (bus_in.addr == ADDR_DEV_TIME) begin
        st_d.rdata = st_q.dev_time;
      end else if (bus_in.addr == ADDR_OVS_PCT) begin
        st_d.rdata = st_q.ovs_pct;
      end else if (bus_in.addr == ADDR_CONTRACT) begin
        st_d.rdata = st_q.contract;
      end else if (bus_in.addr == ADDR_OVS_TIME) begin
        st_d.rdata = st_q.ovs_time;
      end else if (bus_in.addr == ADDR_CONFIG) begin
        st_d.rdata = DATA_W'({st_q.vel_src, st_q.class_460});
      end else if (bus_in.addr == ADDR_STATUS) begin
        st_d.rdata = DATA_W'({st_q.ovs_ok, st_q.low_ok, st_q.ramp, st_q.fault, st_q.alarm, st_q.term});
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      st_q        <= '0;
      st_q.sel[0] <= SEL_RST_0;
      st_q.sel[1] <= SEL_RST_1;
      st_q.sel[2] <= SEL_RST_2;
      st_q.sel[3] <= SEL_RST_N;
      st_q.class_460 <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register
  assign rdata_out = st_q.rdata;
  assign term_out  = st_q.term;
  assign alarm_out = st_q.alarm;
  assign fault_out = st_q.fault;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);

  for (genvar g = 0; g < N_OUT; g++) begin : g_chk
    no_function_a: assert property ((st_q.sel[g] == FN_NONE) |=> !term_out[g])
      else $error("output with no function went true");
  end

  not_alarm_out_a: assert property ((st_q.sel[0] == FN_NOT_ALARM) |=>
      (term_out[0] == !(($past(|status_in.alarm_src)) || ($past(meas_in.temp_c) > OT_ALM_C))))
    else $error("not-alarm output disagrees with alarm");
  ground_trip_a: assert property ((st_q.sel[0] == FN_GROUND_FLT && gf_trip) |=> term_out[0] && fault_out)
    else $error("ground fault not shown");
  overvolt_trip_a: assert property ((st_q.sel[0] == FN_OVERVOLT_FLT) |=>
      (term_out[0] == ($past(meas_in.vbus) > ($past(st_q.class_460) ? OV_460_V : OV_230_V))))
    else $error("overvoltage output wrong for class");
  alarm_temp_a: assert property ((meas_in.temp_c > OT_ALM_C) |=> alarm_out)
    else $error("temperature alarm missed");
  ramp_latch_a: assert property ((status_in.ramp_req_serial) |=> st_q.ramp [*2] or !status_in.run_cmd)
    else $error("ramp stop not latched");
  prepared_out_a: assert property ((st_q.sel[0] == FN_DRIVE_PREPARED) |=>
      (term_out[0] == ($past(status_in.init_done) && !fault_out)))
    else $error("prepared output wrong");
  low_band_a: assert property ((!in_band) |=> !st_q.low_ok && st_q.low_cnt == 16'h0000)
    else $error("low deviation timer not cleared");
  sel_write_a: assert property ((bus_in.wr && bus_in.addr == ADDR_SEL_BASE) |=>
      (st_q.sel[0] == $past(bus_in.wdata[SEL_W-1:0])) && $stable(st_q.sel[1]))
    else $error("selection write failed or disturbed a neighbour");
  reset_low_a: assert property (disable iff (1'b0) (!nrst_in) |=> (term_out == '0))
    else $error("output not false after reset");

endmodule

// ---- tb_top.sv ----
// Self-checking bench for the logic output function selector.
// Assumes the package constants and a short millisecond tick of 4 cycles.
`timescale 1ns/1ps
module tb_top;
  import logic_output_pkg::*;
  localparam int RATED = 100;
  logic                mclk_in = 1'b0;
  logic                nrst_in = 1'b0;
  status_t             s       = '0;
  meas_t               m       = '0;
  bus_req_t            b       = '0;
  logic [DATA_W-1:0]   rdata_out;
  logic [N_OUT-1:0]    term_out;
  logic [6:0]          seen;
  logic                alarm_out;
  logic                fault_out;
  int                  err_count = 0;
  int                  checked   = 0;
  int                  cyc       = 0;
  int                  cfg       = 1;
  logic [7:0]          ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h38, 8'h44};
  logic [15:0]         rv [6] = '{16'h000A, 16'h000B, 16'h0014, 16'h0000, 16'h0001, 16'h0000};
  logic [7:0]          wa [6] = '{ADDR_RATED, ADDR_DEV_LEVEL, ADDR_DEV_BAND, ADDR_DEV_TIME, ADDR_OVS_TIME, ADDR_CONFIG};
  int                  wv [6] = '{RATED, 9, 5, 2, 2, 3};

  ////////////////////////////////////////////////////////////////////////
  // Clock, design and controller model
  initial begin
    forever #2 mclk_in = ~mclk_in;
  end
  logic_output_select #(.TICK_CYCLES(4)) i_dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .status_in(s),
    .meas_in(m), .bus_in(b), .rdata_out(rdata_out), .term_out(term_out), .alarm_out(alarm_out),
    .fault_out(fault_out));
  term_reader i_reader (.mclk_in(mclk_in), .term_in(term_out), .seen_out(seen));

  ////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tk(int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic wr(logic [7:0] a, int d);
    @(posedge mclk_in);
    b <= '{addr: a, wdata: 16'(d), wr: 1'b1, rd: 1'b0};
    @(posedge mclk_in);
    b.wr <= 1'b0;
  endtask
  task automatic rdc(logic [7:0] a, logic [15:0] e);
    @(posedge mclk_in);
    b <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_in);
    b.rd <= 1'b0;
    #1;
    chk("rdata", e, rdata_out);
  endtask
  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Expected terminal level per function code; 30 gives alarm, 31 fault
  function automatic logic expf(int fn);
    logic gf, oc, otf, ov, al, fl, ok;
    gf = int'(m.isum) * 100 > RATED * 50;
    oc = int'(m.iphase) * 100 > RATED * 300;
    otf = m.temp_c > 8'd90;
    ov = int'(m.vbus) > (cfg[0] ? 850 : 425);
    al = (|s.alarm_src) | (m.temp_c > 8'd80);
    fl = (|s.fault_src) | gf | oc | otf | ov | s.fuse_blown | s.phase_open | s.motor_overload;
    ok = s.init_done & !fl;
    case (fn)
      1: return !al;
      2: return gf;
      3: return oc;
      4: return otf;
      5: return ov;
      6: return m.temp_c > 8'd80;
      7: return s.torque_limit & s.motoring;
      8: return s.torque_limit & !s.motoring;
      10: return ok;
      11: return s.run_cmd;
      12: return ok & s.run_cmd & s.contactor_closed & s.gates_firing;
      13: return int'(m.spd_ref) - int'(m.spd_fbk) > 9;
      15: return s.flux_confirmed & !s.dc_injection;
      16: return ok & s.run_cmd & (s.contactor_closed | !s.contact_confirm_used) & !s.dc_injection & (cfg[2:1] == 1);
      17: return s.low_gain;
      18: return s.fuse_blown;
      19: return s.phase_open;
      20: return s.motor_overload;
      30: return al;
      31: return fl;
      default: return 1'b0;
    endcase
  endfunction

  // Input vectors: quiet, healthy at boundaries, faulty past boundaries, low voltage class,
  // healthy again with the contactor check unused and the contactor open
  task automatic setv(int k);
    status_t ns;
    meas_t   nm;
    ns = '0;
    nm = '0;
    case (k)
      1, 4: begin
        ns = '{init_done: 1, run_cmd: 1, contactor_closed: (k == 1), contact_confirm_used: (k == 1),
          gates_firing: 1, torque_limit: 1, motoring: 1, flux_confirmed: 1, low_gain: 1, default: 0};
        nm = '{isum: 50, iphase: 300, temp_c: 80, vbus: 850, spd_ref: 10, default: 0};
        if (k == 4) begin
          wr(ADDR_CONFIG, 3);
          cfg = 3;
        end
      end
      2: begin
        ns = '{init_done: 1, run_cmd: 1, contact_confirm_used: 1, torque_limit: 1, dc_injection: 1,
          flux_confirmed: 1, alarm_src: 1, fuse_blown: 1, phase_open: 1, motor_overload: 1, default: 0};
        nm = '{isum: 51, iphase: 301, temp_c: 91, vbus: 851, spd_ref: 9, default: 0};
      end
      3: begin
        ns = '{init_done: 1, run_cmd: 1, fault_src: 8'h04, default: 0};
        nm = '{temp_c: 81, vbus: 426, default: 0};
        wr(ADDR_CONFIG, 2);
        cfg = 2;
      end
      default: ;
    endcase
    @(posedge mclk_in);
    s <= ns;
    m <= nm;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Hang guard
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      $display("Error timeout expected finish seen hang");
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    tk(10);
    chk("term reset", 16'h0000, 16'(term_out));
    @(posedge mclk_in);
    nrst_in <= 1'b1;
    wr(8'h44, 16'h00FF);
    for (int i = 0; i < 6; i++) rdc(ra[i], rv[i]);
    for (int i = 0; i < 6; i++) wr(wa[i], wv[i]);
    cfg = 3;
    $display("Register test done");
    for (int k = 0; k < 5; k++) begin
      setv(k);
      for (int fn = 0; fn < 24; fn++) begin
        if (fn != 9 && fn != 14 && fn != 21) begin
          wr(ADDR_SEL_BASE, fn);
          tk(1);
          chk("term0", 16'(expf(fn)), 16'(term_out[0]));
          chk("term1", 16'(s.run_cmd), 16'(term_out[1]));
          chk("term2", 16'(s.motor_overload), 16'(term_out[2]));
        end
      end
      chk("term6to3", 16'h0000, 16'(term_out[6:3]));
      chk("alarm", 16'(expf(30)), 16'(alarm_out));
      chk("fault", 16'(expf(31)), 16'(fault_out));
      chk("reader", 16'(term_out), 16'(seen));
      $display("Vector test %0d done", k);
    end
    // Ramp latch from each of the three request sources
    setv(0);
    wr(ADDR_SEL_BASE, 9);
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk_in);
      s <= '{run_cmd: 1, ramp_req_input: (i == 0), ramp_req_serial: (i == 1), ramp_req_internal: (i == 2), default: 0};
      @(posedge mclk_in);
      s <= '{run_cmd: 1, default: 0};
      tk(3);
      chk("ramp set", 16'h0001, 16'(term_out[0]));
      @(posedge mclk_in);
      s.run_cmd <= 1'b0;
      tk(3);
      chk("ramp clear", 16'h0000, 16'(term_out[0]));
    end
    $display("Ramp test done");
    // Timed conditions: low deviation band and overspeed
    wr(ADDR_OVS_PCT, 50);
    wr(ADDR_CONTRACT, 100);
    for (int j = 0; j < 2; j++) begin
      wr(ADDR_SEL_BASE, j ? 21 : 14);
      for (int on = 0; on < 2; on++) begin
        @(posedge mclk_in);
        if (j == 0) m.spd_ref <= on ? 16'sh0005 : 16'sh0006;
        else m.spd_fbk <= on ? 16'sh0033 : 16'sh0032;
        tk(3);
        chk("timer early", 16'h0000, 16'(term_out[0]));
        tk(40);
        chk("timer late", 16'(on), 16'(term_out[0]));
      end
    end
    $display("Timer test done");
    summarize();
  end
endmodule

// ---- term_reader.sv ----
// Model of the elevator controller that reads the drive's output terminals.
// Assumes terminals are registered levels on mclk_in, high meaning true.
`timescale 1ns/1ps
module term_reader (
  input  wire logic       mclk_in,
  input  wire logic [6:0] term_in,
  output logic      [6:0] seen_out
);
  // Controller input latch, sampled on every clock
  always_ff @(posedge mclk_in) begin
    seen_out <= term_in;
  end
endmodule
